// file: gpwd_pkg.sv
/*
 Package of constants for the GPIO port with watchdog.
 Assumes a 200 MHz system clock; used by gpwd_port, gpwd_pad_model and gpwd_port_test.
*/
// What this block does
// - Free pins switch at run time between input, output and open-drain.
// - Module-owned pins follow the module; only invert and open-drain apply.
// - Sampled pin level is reported true and inverted.
// - Direction 0: pin floats with pull-up, readable, output value ignored.
// - Direction 1: pin is an output, style chosen by open-drain select.
// - Push-pull output drives output value after optional inversion.
// - Open-drain output drives low for 0, floats for 1, level readable.
// - Flip select complements driven level; ignored while pin is input.
// - Watchdog dormant after reset, armed and restarted by host write cycles.
// - Expiry interval held in nanoseconds, initialised to five million.
// - Expiry floats all pins with pull-up, detaches modules, stops host traffic.
// - Expiry leaves internal module state running.
// - Expired flag set on expiry; clearing it restores traffic and reset pin config.
// - Host read cycle captures pin levels and module feedback.
// - Host write cycle applies outputs and pending configuration together.
package gpwd_pkg;
   localparam int PIN_COUNT = 8;
   localparam int FEEDBACK_WIDTH = 16;
   localparam int CLOCK_PERIOD_NS = 5;
   localparam logic [31:0] EXPIRY_INTERVAL_RESET = 32'h004C4B40;
   localparam logic [31:0] NS_PER_CYCLE = 32'(CLOCK_PERIOD_NS);
   localparam logic [PIN_COUNT-1:0] PIN_CONFIG_RESET = 8'h00;
   typedef enum logic [1:0] {
      GPWD_DORMANT = 2'b00,
      GPWD_ARMED = 2'b01,
      GPWD_EXPIRED = 2'b10
   } gpwd_state_type;
endpackage

// file: gpwd_pin_cell.sv
/*
 One pin's output stage: chooses drive level and enable for a pin.
 Assumes the enable is active low and the pad adds a weak pull-up.
*/
`timescale 1ns/10ps
module gpwd_pin_cell (
   input wire logic owned,
   input wire logic moduleDrive,
   input wire logic moduleOut,
   input wire logic direction,
   input wire logic openDrain,
   input wire logic flip,
   input wire logic outValue,
   input wire logic expired,
   output logic padOut,
   output logic padEnable_n
);
   logic isOut;
   logic level;
   always_comb begin
      isOut = owned ? moduleDrive : direction;
      level = (owned ? moduleOut : outValue) ^ flip;
      padOut = 1'b0;
      padEnable_n = 1'b1;
      if (expired || !isOut) begin
         padEnable_n = 1'b1;
      end else if (openDrain) begin
         padEnable_n = level;
      end else begin
         padOut = level;
         padEnable_n = 1'b0;
      end
   end
endmodule

// file: gpwd_port.sv
/*
 GPIO port with watchdog: holds pin configuration applied on host write cycles,
 captures inputs on host read cycles and floats every pin on watchdog expiry.
 Assumes hostWrite/hostRead are single-cycle pulses from logic on clk_sys and
 that pin inputs are asynchronous.
*/
`timescale 1ns/10ps
module gpwd_port (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic hostWrite,
   input wire logic hostRead,
   input wire logic [gpwd_pkg::PIN_COUNT-1:0] pinDirectionSelect,
   input wire logic [gpwd_pkg::PIN_COUNT-1:0] openDrainSelect,
   input wire logic [gpwd_pkg::PIN_COUNT-1:0] flipSelect,
   input wire logic [gpwd_pkg::PIN_COUNT-1:0] outValue,
   input wire logic [31:0] expiryInterval,
   input wire logic expiryIntervalLoad,
   input wire logic expiredClear,
   input wire logic [gpwd_pkg::PIN_COUNT-1:0] moduleOwned,
   input wire logic [gpwd_pkg::PIN_COUNT-1:0] moduleDrive,
   input wire logic [gpwd_pkg::PIN_COUNT-1:0] moduleOut,
   input wire logic [gpwd_pkg::FEEDBACK_WIDTH-1:0] moduleFeedback,
   input wire logic [gpwd_pkg::PIN_COUNT-1:0] pinIn,
   output logic [gpwd_pkg::PIN_COUNT-1:0] pinOut,
   output logic [gpwd_pkg::PIN_COUNT-1:0] pinEnable_n,
   output logic [gpwd_pkg::PIN_COUNT-1:0] pinLevel,
   output logic [gpwd_pkg::PIN_COUNT-1:0] pinLevelInverted,
   output logic [gpwd_pkg::PIN_COUNT-1:0] moduleIn,
   output logic [gpwd_pkg::FEEDBACK_WIDTH-1:0] feedbackCapture,
   output logic readDone,
   output logic expired,
   output logic [31:0] expiryIntervalValue
);
   localparam int N = gpwd_pkg::PIN_COUNT;
   // ==========================================================================
   // Input synchroniser
   // ==========================================================================
   logic [N-1:0] syncFirst, syncSecond;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         syncFirst <= '0;
         syncSecond <= '0;
      end else begin
         syncFirst <= pinIn;
         syncSecond <= syncFirst;
      end
   end
   // ==========================================================================
   // Watchdog
   // ==========================================================================
   gpwd_pkg::gpwd_state_type state, next_state;
   logic [31:0] elapsed, next_elapsed, interval, next_interval;
   logic accepted;
   // Host traffic is dropped while expired, so a write cannot rearm silently.
   assign accepted = state != gpwd_pkg::GPWD_EXPIRED;
   always_comb begin
      next_state = state;
      next_elapsed = elapsed;
      next_interval = expiryIntervalLoad ? expiryInterval : interval;
      case (state)
         gpwd_pkg::GPWD_DORMANT: begin
            if (hostWrite) begin
               next_state = gpwd_pkg::GPWD_ARMED;
               next_elapsed = '0;
            end
         end
         gpwd_pkg::GPWD_ARMED: begin
            if (hostWrite) begin
               next_elapsed = '0;
            end else if (elapsed + gpwd_pkg::NS_PER_CYCLE >= interval) begin
               next_state = gpwd_pkg::GPWD_EXPIRED;
            end else begin
               next_elapsed = elapsed + gpwd_pkg::NS_PER_CYCLE;
            end
         end
         gpwd_pkg::GPWD_EXPIRED: begin
            if (expiredClear) begin
               next_state = gpwd_pkg::GPWD_DORMANT;
               next_elapsed = '0;
            end
         end
         default: next_state = gpwd_pkg::GPWD_DORMANT;
      endcase
   end
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state <= gpwd_pkg::GPWD_DORMANT;
         elapsed <= '0;
         interval <= gpwd_pkg::EXPIRY_INTERVAL_RESET;
      end else begin
         state <= next_state;
         elapsed <= next_elapsed;
         interval <= next_interval;
      end
   end
   // ==========================================================================
   // Applied configuration, updated on accepted write cycles, reset when expiry is cleared
   // ==========================================================================
   logic [N-1:0] dirApplied, odApplied, flipApplied, outApplied;
   logic [N-1:0] next_dirApplied, next_odApplied, next_flipApplied, next_outApplied;
   logic applyWrite, restore;
   assign applyWrite = hostWrite && accepted;
   assign restore = (state == gpwd_pkg::GPWD_EXPIRED) && expiredClear;
   always_comb begin
      next_dirApplied = dirApplied;
      next_odApplied = odApplied;
      next_flipApplied = flipApplied;
      next_outApplied = outApplied;
      if (restore) begin
         next_dirApplied = gpwd_pkg::PIN_CONFIG_RESET;
         next_odApplied = gpwd_pkg::PIN_CONFIG_RESET;
         next_flipApplied = gpwd_pkg::PIN_CONFIG_RESET;
         next_outApplied = gpwd_pkg::PIN_CONFIG_RESET;
      end else if (applyWrite) begin
         next_dirApplied = pinDirectionSelect;
         next_odApplied = openDrainSelect;
         next_flipApplied = flipSelect;
         next_outApplied = outValue;
      end
   end
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         dirApplied <= gpwd_pkg::PIN_CONFIG_RESET;
         odApplied <= gpwd_pkg::PIN_CONFIG_RESET;
         flipApplied <= gpwd_pkg::PIN_CONFIG_RESET;
         outApplied <= gpwd_pkg::PIN_CONFIG_RESET;
      end else begin
         dirApplied <= next_dirApplied;
         odApplied <= next_odApplied;
         flipApplied <= next_flipApplied;
         outApplied <= next_outApplied;
      end
   end
   // ==========================================================================
   // Pin cells and registered pad outputs
   // ==========================================================================
   logic [N-1:0] cellOut, cellEnable_n;
   logic expiring;
   assign expiring = (next_state == gpwd_pkg::GPWD_EXPIRED);
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_pin
         gpwd_pin_cell u_cell (
            .owned(moduleOwned[i]),
            .moduleDrive(moduleDrive[i]),
            .moduleOut(moduleOut[i]),
            .direction(next_dirApplied[i]),
            .openDrain(next_odApplied[i]),
            .flip(next_flipApplied[i]),
            .outValue(next_outApplied[i]),
            .expired(expiring),
            .padOut(cellOut[i]),
            .padEnable_n(cellEnable_n[i])
         );
      end
   endgenerate
   // Modules keep running while expired; only their pin drive is cut, moduleIn still follows the pins.
   logic [N-1:0] next_pinLevel, next_moduleIn;
   logic [gpwd_pkg::FEEDBACK_WIDTH-1:0] next_feedback;
   always_comb begin
      next_pinLevel = pinLevel;
      next_feedback = feedbackCapture;
      if (hostRead && accepted) begin
         next_pinLevel = syncSecond;
         next_feedback = moduleFeedback;
      end
      next_moduleIn = syncSecond;
   end
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pinOut <= '0;
         pinEnable_n <= '1;
         pinLevel <= '0;
         pinLevelInverted <= '1;
         moduleIn <= '0;
         feedbackCapture <= '0;
         readDone <= 1'b0;
         expired <= 1'b0;
         expiryIntervalValue <= gpwd_pkg::EXPIRY_INTERVAL_RESET;
      end else begin
         pinOut <= cellOut;
         pinEnable_n <= cellEnable_n;
         pinLevel <= next_pinLevel;
         pinLevelInverted <= ~next_pinLevel;
         moduleIn <= next_moduleIn;
         feedbackCapture <= next_feedback;
         readDone <= hostRead && accepted;
         expired <= expiring;
         expiryIntervalValue <= next_interval;
      end
   end
   // ==========================================================================
   // Checks
   // ==========================================================================
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   a_expiry_floats_pins: assert property (expired |-> pinEnable_n == '1)
      else $error("pin driven while expired");
   a_inverted_level: assert property (pinLevelInverted == ~pinLevel)
      else $error("inverted level mismatch");
   a_dormant_no_expiry: assert property (state == gpwd_pkg::GPWD_DORMANT && !hostWrite
      |=> state != gpwd_pkg::GPWD_EXPIRED)
      else $error("dormant watchdog expired");
   a_write_restarts: assert property (state == gpwd_pkg::GPWD_ARMED && hostWrite
      |=> elapsed == 32'h0 && !expired)
      else $error("write did not restart watchdog");
   a_clear_restores: assert property (expired && expiredClear
      |=> !expired && dirApplied == '0)
      else $error("clear did not restore");
   a_config_holds: assert property (!hostWrite && !restore
      |=> $stable(dirApplied) && $stable(flipApplied))
      else $error("configuration changed without write");
   // Ownership feeds the pad register directly, so the check looks at last cycle's value.
   a_input_floats: assert property (!expired && !$past(moduleOwned[0]) && !dirApplied[0]
      |-> pinEnable_n[0])
      else $error("input pin driven");
   a_read_capture: assert property (hostRead && accepted
      |=> pinLevel == $past(syncSecond) && readDone)
      else $error("read did not capture");
   a_pushpull_drive: assert property (!expired && !$past(moduleOwned[0]) && dirApplied[0]
      && !odApplied[0] |-> !pinEnable_n[0] && pinOut[0] == (outApplied[0] ^ flipApplied[0]))
      else $error("push-pull drive wrong");
   c_arm: cover property (state == gpwd_pkg::GPWD_DORMANT && hostWrite);
   c_expire: cover property (!expired ##1 expired);
   c_restore: cover property (expired && expiredClear);
   c_open_drain: cover property (dirApplied[0] && odApplied[0] && pinEnable_n[0]);
endmodule

// file: gpwd_pad_model.sv
/*
 Pad model for the GPIO port: resolves each pin from the port's drive,
 an external driver and the weak pull-up.
 Assumes the port's drive enable is active low.
*/
`timescale 1ns/10ps
module gpwd_pad_model (
   input wire logic [gpwd_pkg::PIN_COUNT-1:0] pinOut,
   input wire logic [gpwd_pkg::PIN_COUNT-1:0] pinEnable_n,
   input wire logic [gpwd_pkg::PIN_COUNT-1:0] extEnable,
   input wire logic [gpwd_pkg::PIN_COUNT-1:0] extValue,
   output logic [gpwd_pkg::PIN_COUNT-1:0] pinIn
);
   // Any low driver wins; the bench never sets up a push-pull fight.
   always_comb begin
      for (int i = 0; i < gpwd_pkg::PIN_COUNT; i++) begin
         pinIn[i] = 1'b1;
         if (!pinEnable_n[i]) pinIn[i] = pinOut[i];
         if (extEnable[i] && !extValue[i]) pinIn[i] = 1'b0;
      end
   end
endmodule

// file: gpwd_port_test.sv
/*
 Self-checking bench for the GPIO port with watchdog.
 Assumes gpwd_pad_model closes the pins and the design's 200 MHz clock.
*/
`timescale 1ns/10ps
module gpwd_port_test;
   localparam int N = gpwd_pkg::PIN_COUNT;
   logic clk_sys, reset_n, hostWrite, hostRead, intervalLoad, expiredClear, readDone, expired;
   logic [N-1:0] dirSel, odSel, flipSel, outVal, owned, modDrive, modOut, extEn, extVal;
   logic [N-1:0] pinIn, pinOut, pinEnable_n, pinLevel, pinLevelInv, moduleIn;
   logic [gpwd_pkg::FEEDBACK_WIDTH-1:0] feedback, feedbackCapture;
   logic [31:0] interval, intervalValue;
   int numErrors, checksDone, k;
   gpwd_port dut (.clk_sys(clk_sys), .reset_n(reset_n), .hostWrite(hostWrite),
      .hostRead(hostRead), .pinDirectionSelect(dirSel), .openDrainSelect(odSel),
      .flipSelect(flipSel), .outValue(outVal), .expiryInterval(interval),
      .expiryIntervalLoad(intervalLoad), .expiredClear(expiredClear), .moduleOwned(owned),
      .moduleDrive(modDrive), .moduleOut(modOut), .moduleFeedback(feedback), .pinIn(pinIn),
      .pinOut(pinOut), .pinEnable_n(pinEnable_n), .pinLevel(pinLevel),
      .pinLevelInverted(pinLevelInv), .moduleIn(moduleIn), .feedbackCapture(feedbackCapture),
      .readDone(readDone), .expired(expired), .expiryIntervalValue(intervalValue));
   gpwd_pad_model pads (.pinOut(pinOut), .pinEnable_n(pinEnable_n), .extEnable(extEn),
      .extValue(extVal), .pinIn(pinIn));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // ==========================================================
   // Access tasks
   task tick;
      @(posedge clk_sys);
      #1;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         numErrors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Ends one cycle after the sampling edge so strobes never toggle twice in a step.
   task host_write(input logic [N-1:0] d, o, f, v);
      dirSel = d;
      odSel = o;
      flipSel = f;
      outVal = v;
      hostWrite = 1'b1;
      tick;
      hostWrite = 1'b0;
      tick;
   endtask
   task host_read;
      hostRead = 1'b1;
      tick;
      hostRead = 1'b0;
   endtask
   task complete_run;
      $display("checks %0d errors %0d", checksDone, numErrors);
      if (numErrors == 0 && checksDone > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   initial begin
      {reset_n, hostWrite, hostRead, intervalLoad, expiredClear} = 5'h00;
      {dirSel, odSel, flipSel, outVal, owned, modDrive, modOut, extEn, extVal} = '0;
      feedback = 16'hC3A5;
      interval = 32'h00000032;
      numErrors = 0;
      checksDone = 0;
      repeat (5) @(posedge clk_sys);
      #1;
      reset_n = 1'b1;
      chk(pinEnable_n, 8'hFF);
      chk(expired, 1'b0);
      chk(intervalValue, 32'h004C4B40);
      intervalLoad = 1'b1;
      tick;
      intervalLoad = 1'b0;
      repeat (30) tick;
      chk(intervalValue, 32'h00000032);
      chk(expired, 1'b0);
      host_write(8'hFF, 8'h00, 8'h0F, 8'hA5);
      chk(pinEnable_n, 8'h00);
      chk(pinOut, 8'hAA);
      dirSel = 8'h00;
      outVal = 8'h00;
      repeat (3) tick;
      chk(pinOut, 8'hAA);
      extEn = 8'h01;
      host_write(8'hFF, 8'hFF, 8'h00, 8'h0F);
      chk(pinEnable_n, 8'h0F);
      chk(pinOut & ~pinEnable_n, 8'h00);
      tick;
      host_read;
      chk(readDone, 1'b1);
      chk(pinLevel, 8'h0E);
      chk(pinLevelInv, 8'hF1);
      chk(feedbackCapture, 16'hC3A5);
      tick;
      extEn = 8'hFF;
      extVal = 8'h5A;
      host_write(8'h00, 8'hFF, 8'hFF, 8'hFF);
      chk(pinEnable_n, 8'hFF);
      tick;
      host_read;
      chk(pinLevel, 8'h5A);
      tick;
      extEn = 8'h00;
      owned = 8'h03;
      modDrive = 8'h01;
      modOut = 8'h01;
      host_write(8'h00, 8'h00, 8'h02, 8'h00);
      chk(pinEnable_n, 8'hFE);
      chk(pinOut[0], 1'b1);
      repeat (4) begin
         repeat (6) tick;
         host_write(8'h00, 8'h00, 8'h02, 8'h00);
      end
      chk(expired, 1'b0);
      k = 1;
      while (expired !== 1'b1 && k < 20) begin
         tick;
         k++;
      end
      if (k >= 20) begin
         numErrors++;
         complete_run;
      end
      chk(k, 32'h00000032 / gpwd_pkg::CLOCK_PERIOD_NS);
      chk(pinEnable_n, 8'hFF);
      extEn = 8'h01;
      repeat (3) tick;
      chk(moduleIn, 8'hFE);
      host_write(8'hFF, 8'h00, 8'h00, 8'h00);
      chk(pinEnable_n, 8'hFF);
      host_read;
      chk(readDone, 1'b0);
      owned = 8'h00;
      expiredClear = 1'b1;
      tick;
      expiredClear = 1'b0;
      chk(expired, 1'b0);
      chk(pinEnable_n, 8'hFF);
      tick;
      host_write(8'hFE, 8'h00, 8'h00, 8'h55);
      chk(pinEnable_n, 8'h01);
      chk(pinOut & 8'hFE, 8'h54);
      complete_run;
   end
endmodule
